/* File: verilog/tw_target.sv */
// two-wire target: wake detection, bus protocol, command collection, watchdog
// Behaviour
// - asleep: only long data-low wakes device
// - clock ignored until wake delay ends
// - woken non-addressed devices stay off bus
// - wake sequence ignored while already awake
// - bits sampled on clock rise, stable high
// - data fall with clock high starts transaction
// - stop ends transaction; a full command starts before the stop
// - execution starts when byte count reached
// - watchdog expiry returns device to sleep
// - ninth clock low acknowledges each byte
// - ninth clock high means not acknowledged
// - data pin is open drain only
// - protocol timing served up to 1 MHz
// - seven address bits programmable, bit three threshold
// - claim only when address bits 7:1 match
// - second byte selects reset, sleep, idle, command
// - first byte is length, extras discarded
// - read address refused while executing
module tw_target #(
  parameter int DEPTH         = tw_pkg::BUF_DEPTH,
  parameter int WAKE_HIGH_CYC = tw_pkg::WAKE_HIGH_CYC,
  parameter int WATCHDOG_CYC  = tw_pkg::WATCHDOG_CYC
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       scl_in,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe,
  input  wire logic [7:0]                 dev_addr,
  output logic                            thresh_ttl,
  output logic                            awake,
  output logic                            busy,
  output logic                            exec_start,
  output logic [7:0]                      cmd_len,
  input  wire logic                       exec_done,
  input  wire logic [$clog2(DEPTH)-1:0]   buf_rd_addr,
  output logic [7:0]                      buf_rd_data,
  input  wire logic [7:0]                 resp_data,
  output logic                            resp_next,
  output logic                            resp_rewind,
  output logic                            sleep_req,
  output logic                            idle_req
);
  localparam int AW = $clog2(DEPTH);

  // clock must give enough samples per bus clock half period
  if (tw_pkg::SCL_HALF_CYC < tw_pkg::MIN_HALF_CYC)
  begin : g_bad_clk
    $error("system clock too slow for the bus clock rate");
  end
  if (DEPTH < 2 || DEPTH > 256 || (1 << AW) != DEPTH || WAKE_HIGH_CYC < 1 || WATCHDOG_CYC < 1)
  begin : g_bad_par
    $error("unsupported buffer depth or timing parameter");
  end

  tw_buf_if #(.DEPTH(DEPTH)) buf_if ();

  tw_cmd_buf #(.DEPTH(DEPTH)) u_buf (
    .clk_sys (clk_sys),
    .rst     (rst),
    .port    (buf_if.mem)
  );

  logic scl;
  logic sda;

  tw_pin_sync u_scl_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin     (scl_in),
    .level   (scl)
  );

  tw_pin_sync u_sda_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin     (sda_in),
    .level   (sda)
  );

  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_rise   = scl & ~scl_q;
  assign scl_fall   = ~scl & scl_q;
  assign start_cond = scl & scl_q & sda_q & ~sda;
  assign stop_cond  = scl & scl_q & ~sda_q & sda;

  // the pin only ever pulls low; the pull-up makes the high level
  assign sda_out = 1'b0;

  // power state
  tw_pkg::tw_pwr_e pwr;
  tw_pkg::tw_pwr_e next_pwr;
  logic [31:0]     tmr;
  logic [31:0]     next_tmr;
  logic [31:0]     wdog;
  logic [31:0]     next_wdog;

  always_comb
  begin
    next_pwr  = pwr;
    next_tmr  = tmr;
    next_wdog = wdog;
    case (pwr)
      tw_pkg::pwr_sleep:
      begin
        if (!sda)
        begin
          next_pwr = tw_pkg::pwr_wake_low;
          next_tmr = 32'h1;
        end
      end
      tw_pkg::pwr_wake_low:
      begin
        if (sda)
        begin
          next_tmr = 32'h0;
          if (tmr >= 32'(tw_pkg::WAKE_LOW_CYC))
          begin
            next_pwr = tw_pkg::pwr_wake_high;
          end
          else
          begin
            next_pwr = tw_pkg::pwr_sleep;
          end
        end
        else if (tmr < 32'(tw_pkg::WAKE_LOW_CYC))
        begin
          next_tmr = tmr + 32'h1;
        end
      end
      tw_pkg::pwr_wake_high:
      begin
        // clock handling stays off until this delay has run out
        next_tmr = tmr + 32'h1;
        if (tmr >= 32'(WAKE_HIGH_CYC - 1))
        begin
          next_pwr  = tw_pkg::pwr_awake;
          next_wdog = 32'h0;
        end
      end
      tw_pkg::pwr_awake:
      begin
        // no wake detection here, so a second wake leaves the power state and watchdog alone; the bus logic sees it as start then stop
        if (!busy)
        begin
          next_wdog = wdog + 32'h1;
        end
        if (sleep_req || idle_req || wdog >= 32'(WATCHDOG_CYC - 1))
        begin
          next_pwr = tw_pkg::pwr_sleep;
          next_tmr = 32'h0;
        end
      end
      default:
      begin
        next_pwr = tw_pkg::pwr_sleep;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pwr  <= tw_pkg::pwr_sleep;
      tmr  <= 32'h0;
      wdog <= 32'h0;
    end
    else
    begin
      pwr  <= next_pwr;
      tmr  <= next_tmr;
      wdog <= next_wdog;
    end
  end

  // bus protocol and command collection
  tw_pkg::tw_bus_e bus;
  tw_pkg::tw_bus_e next_bus;
  logic [3:0]      bits;
  logic [3:0]      next_bits;
  logic [7:0]      shreg;
  logic [7:0]      next_shreg;
  logic            rw;
  logic            next_rw;
  logic            first;
  logic            next_first;
  logic [7:0]      wa;
  logic [7:0]      next_wa;
  logic            wa_ok;
  logic            next_wa_ok;
  logic [AW:0]     ptr;
  logic [AW:0]     next_ptr;
  logic            next_sda_oe;
  logic            next_busy;
  logic            next_exec_start;
  logic [7:0]      next_cmd_len;
  logic            next_resp_next;
  logic            next_resp_rewind;
  logic            next_sleep_req;
  logic            next_idle_req;
  logic            next_wr_en;
  logic [AW-1:0]   next_wr_addr;
  logic [7:0]      next_wr_data;
  logic            next_thresh_ttl;

  always_comb
  begin
    logic [7:0] limit;
    limit            = (ptr == '0) ? shreg : cmd_len;
    next_bus         = bus;
    next_bits        = bits;
    next_shreg       = shreg;
    next_rw          = rw;
    next_first       = first;
    next_wa          = wa;
    next_wa_ok       = wa_ok;
    next_ptr         = ptr;
    next_sda_oe      = sda_oe;
    next_busy        = busy;
    next_cmd_len     = cmd_len;
    next_exec_start  = 1'b0;
    next_resp_next   = 1'b0;
    next_resp_rewind = 1'b0;
    next_sleep_req   = 1'b0;
    next_idle_req    = 1'b0;
    next_wr_en       = 1'b0;
    next_wr_addr     = ptr[AW-1:0];
    next_wr_data     = shreg;
    next_thresh_ttl  = dev_addr[tw_pkg::ADDR_TTL_BIT];
    if (exec_done && busy)
    begin
      next_busy    = 1'b0;
      next_ptr     = '0;
      next_cmd_len = 8'h00;
    end
    if (pwr != tw_pkg::pwr_awake)
    begin
      next_bus    = tw_pkg::bus_idle;
      next_sda_oe = 1'b0;
      next_wa_ok  = 1'b0;
    end
    else if (start_cond)
    begin
      next_bus    = tw_pkg::bus_addr;
      next_bits   = 4'h0;
      next_sda_oe = 1'b0;
    end
    else if (stop_cond)
    begin
      next_bus    = tw_pkg::bus_idle;
      next_sda_oe = 1'b0;
      next_wa_ok  = 1'b0;
      next_sleep_req = wa_ok && (wa == tw_pkg::WA_SLEEP);
      next_idle_req  = wa_ok && (wa == tw_pkg::WA_IDLE);
    end
    else
    begin
      case (bus)
        tw_pkg::bus_addr:
        begin
          if (scl_rise)
          begin
            next_shreg = {shreg[6:0], sda};
            next_bits  = bits + 4'h1;
          end
          else if (scl_fall && bits == tw_pkg::BITS_BYTE)
          begin
            if (shreg[7:1] == dev_addr[7:1] && !(shreg[0] && busy))
            begin
              next_sda_oe = 1'b1;
              next_rw     = shreg[0];
              next_bus    = tw_pkg::bus_addr_ack;
            end
            else
            begin
              next_bus = tw_pkg::bus_skip;
            end
          end
        end
        tw_pkg::bus_addr_ack, tw_pkg::bus_rd_ack:
        begin
          if (scl_rise && bus == tw_pkg::bus_rd_ack && sda)
          begin
            next_bus = tw_pkg::bus_skip;
          end
          else if (scl_fall)
          begin
            next_bits = 4'h0;
            if (rw)
            begin
              next_shreg     = resp_data;
              next_resp_next = 1'b1;
              next_sda_oe    = ~resp_data[7];
              next_bus       = tw_pkg::bus_rd;
            end
            else
            begin
              next_sda_oe = 1'b0;
              next_first  = 1'b1;
              next_bus    = tw_pkg::bus_wr;
            end
          end
        end
        tw_pkg::bus_rd:
        begin
          if (scl_fall)
          begin
            if (bits == tw_pkg::BITS_LAST)
            begin
              next_sda_oe = 1'b0;
              next_bits   = 4'h0;
              next_bus    = tw_pkg::bus_rd_ack;
            end
            else
            begin
              next_shreg  = {shreg[6:0], 1'b0};
              next_sda_oe = ~shreg[6];
              next_bits   = bits + 4'h1;
            end
          end
        end
        tw_pkg::bus_wr:
        begin
          if (scl_rise)
          begin
            next_shreg = {shreg[6:0], sda};
            next_bits  = bits + 4'h1;
          end
          else if (scl_fall && bits == tw_pkg::BITS_BYTE)
          begin
            next_sda_oe = 1'b1;
            next_bus    = tw_pkg::bus_wr_ack;
            if (first)
            begin
              next_first = 1'b0;
              next_wa    = shreg;
              next_wa_ok = (shreg <= tw_pkg::WA_CMD);
              if (shreg > tw_pkg::WA_CMD)
              begin
                next_sda_oe = 1'b0;
                next_bus    = tw_pkg::bus_skip;
              end
              else if (shreg == tw_pkg::WA_RESET && !busy)
              begin
                next_ptr         = '0;
                next_resp_rewind = 1'b1;
              end
            end
            else if (wa == tw_pkg::WA_CMD && !busy && (ptr == '0 || 32'(ptr) < 32'(cmd_len)))
            begin
              // bytes past the length or while executing are acked and dropped
              next_wr_en = 1'b1;
              next_ptr   = ptr + 1'b1;
              if (ptr == '0)
              begin
                next_cmd_len = shreg;
              end
              if (32'(ptr) + 1 >= 32'(limit) || 32'(ptr) + 1 >= DEPTH)
              begin
                next_exec_start = 1'b1;
                next_busy       = 1'b1;
              end
            end
          end
        end
        tw_pkg::bus_wr_ack:
        begin
          if (scl_fall)
          begin
            next_sda_oe = 1'b0;
            next_bits   = 4'h0;
            next_bus    = tw_pkg::bus_wr;
          end
        end
        default:
        begin
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      scl_q       <= tw_pkg::PIN_RESET;
      sda_q       <= tw_pkg::PIN_RESET;
      bus         <= tw_pkg::bus_idle;
      bits        <= 4'h0;
      shreg       <= 8'h00;
      rw          <= 1'b0;
      first       <= 1'b0;
      wa          <= 8'h00;
      wa_ok       <= 1'b0;
      ptr         <= '0;
      sda_oe      <= 1'b0;
      busy        <= 1'b0;
      cmd_len     <= 8'h00;
      exec_start  <= 1'b0;
      resp_next   <= 1'b0;
      resp_rewind <= 1'b0;
      sleep_req   <= 1'b0;
      idle_req    <= 1'b0;
      thresh_ttl  <= 1'b0;
      buf_if.wr_en   <= 1'b0;
      buf_if.wr_addr <= '0;
      buf_if.wr_data <= 8'h00;
    end
    else
    begin
      scl_q       <= scl;
      sda_q       <= sda;
      bus         <= next_bus;
      bits        <= next_bits;
      shreg       <= next_shreg;
      rw          <= next_rw;
      first       <= next_first;
      wa          <= next_wa;
      wa_ok       <= next_wa_ok;
      ptr         <= next_ptr;
      sda_oe      <= next_sda_oe;
      busy        <= next_busy;
      cmd_len     <= next_cmd_len;
      exec_start  <= next_exec_start;
      resp_next   <= next_resp_next;
      resp_rewind <= next_resp_rewind;
      sleep_req   <= next_sleep_req;
      idle_req    <= next_idle_req;
      thresh_ttl  <= next_thresh_ttl;
      buf_if.wr_en   <= next_wr_en;
      buf_if.wr_addr <= next_wr_addr;
      buf_if.wr_data <= next_wr_data;
    end
  end

  assign awake          = (pwr == tw_pkg::pwr_awake);
  assign buf_if.rd_addr = buf_rd_addr;
  assign buf_rd_data    = buf_if.rd_data;
endmodule : tw_target

/* File: verilog/tw_pkg.sv */
// constants, timing and state types of the two-wire target wake logic
package tw_pkg;
  localparam int CLK_MHZ            = 40;
  localparam int WAKE_LOW_TIME_NS   = 60000;
  localparam int WAKE_LOW_CYC       = (WAKE_LOW_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_HIGH_DELAY_US = 1500;
  localparam int WAKE_HIGH_CYC      = WAKE_HIGH_DELAY_US * CLK_MHZ;
  localparam int WATCHDOG_TIME_MS   = 1300;
  localparam int WATCHDOG_CYC       = WATCHDOG_TIME_MS * 1000 * CLK_MHZ;
  localparam int MAX_SCL_KHZ        = 1000;
  localparam int SCL_HALF_CYC       = (CLK_MHZ * 1000) / (2 * MAX_SCL_KHZ);
  localparam int MIN_HALF_CYC       = 8;
  localparam int BUF_DEPTH          = 64;
  localparam int ADDR_TTL_BIT       = 3;
  localparam logic [3:0] BITS_BYTE  = 4'h8;
  localparam logic [3:0] BITS_LAST  = 4'h7;
  localparam logic [7:0] WA_RESET   = 8'h00;
  localparam logic [7:0] WA_SLEEP   = 8'h01;
  localparam logic [7:0] WA_IDLE    = 8'h02;
  localparam logic [7:0] WA_CMD     = 8'h03;
  localparam logic       PIN_RESET  = 1'b1;

  typedef enum logic [1:0] {pwr_sleep, pwr_wake_low, pwr_wake_high, pwr_awake} tw_pwr_e;
  typedef enum logic [2:0] {bus_idle, bus_addr, bus_addr_ack, bus_wr, bus_wr_ack,
                            bus_rd, bus_rd_ack, bus_skip} tw_bus_e;
endpackage : tw_pkg

/* File: verilog/tw_buf_if.sv */
// carrier between the target logic and its command buffer
interface tw_buf_if #(parameter int DEPTH = 64);
  localparam int AW = $clog2(DEPTH);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0]    wr_data;
  logic [AW-1:0] rd_addr;
  logic [7:0]    rd_data;
  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : tw_buf_if

/* File: verilog/tw_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
module tw_pin_sync (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  // a change counts only once the last two stages agree
  always_comb
  begin
    next_level = level;
    if (s2 == s3)
    begin
      next_level = s3;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s1    <= tw_pkg::PIN_RESET;
      s2    <= tw_pkg::PIN_RESET;
      s3    <= tw_pkg::PIN_RESET;
      level <= tw_pkg::PIN_RESET;
    end
    else
    begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end
endmodule : tw_pin_sync

/* File: verilog/tw_cmd_buf.sv */
// command input buffer with registered read data
module tw_cmd_buf #(parameter int DEPTH = 64) (
  input  wire logic clk_sys,
  input  wire logic rst,
  tw_buf_if.mem     port
);
  logic [7:0] mem [DEPTH];
  logic [7:0] next_rd_data;

  always_comb
  begin
    next_rd_data = mem[port.rd_addr];
  end

  // the array has no reset; contents are valid only below the write pointer
  always_ff @(posedge clk_sys)
  begin
    if (port.wr_en)
    begin
      mem[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      port.rd_data <= 8'h00;
    end
    else
    begin
      port.rd_data <= next_rd_data;
    end
  end
endmodule : tw_cmd_buf

/* File: verilog/tw_target_dummy_never.sv */
// holds no logic; the target is built from the other design files

/* File: testbench/tw_target_properties.sv */
// concurrent checks on the two-wire target ports
module tw_target_properties #(
  parameter int DEPTH         = 64,
  parameter int WAKE_HIGH_CYC = 20,
  parameter int WATCHDOG_CYC  = 5000
) (
  input wire logic                     clk_sys,
  input wire logic                     rst,
  input wire logic                     scl_in,
  input wire logic                     sda_in,
  input wire logic                     sda_out,
  input wire logic                     sda_oe,
  input wire logic [7:0]               dev_addr,
  input wire logic                     thresh_ttl,
  input wire logic                     awake,
  input wire logic                     busy,
  input wire logic                     exec_start,
  input wire logic [7:0]               cmd_len,
  input wire logic                     exec_done,
  input wire logic [$clog2(DEPTH)-1:0] buf_rd_addr,
  input wire logic [7:0]               buf_rd_data,
  input wire logic [7:0]               resp_data,
  input wire logic                     resp_next,
  input wire logic                     resp_rewind,
  input wire logic                     sleep_req,
  input wire logic                     idle_req
);
  timeunit 1ns;
  timeprecision 100ps;
  int hi_cnt;
  int wd_cnt;

  // raw high run is never shorter than the filtered one, so the bound stays safe
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      hi_cnt <= 0;
      wd_cnt <= 0;
    end
    else
    begin
      hi_cnt <= sda_in ? hi_cnt + 1 : 0;
      wd_cnt <= !awake ? 0 : (busy ? wd_cnt : wd_cnt + 1);
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_leave_awake;
    ##[0:2] !awake;
  endsequence
  sequence s_busy_soon;
    ##[0:1] busy;
  endsequence

  a_open_drain_only: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_quiet_asleep: assert property (!awake && !$past(awake) |-> !sda_oe)
    else $error("data pin driven while asleep");
  a_drive_clock_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed with clock high");
  a_exec_one_shot: assert property (exec_start |=> !exec_start)
    else $error("execution start longer than one cycle");
  a_exec_sets_busy: assert property (exec_start |-> s_busy_soon)
    else $error("busy missing after execution start");
  a_busy_until_done: assert property (busy && !exec_done && !$past(exec_done) |=> busy)
    else $error("busy dropped without completion");
  a_len_cleared: assert property (exec_done |-> ##[1:2] cmd_len == 8'h00)
    else $error("length not cleared after completion");
  a_sleep_drops: assert property (sleep_req || idle_req |-> s_leave_awake)
    else $error("still awake after sleep or idle");
  a_wake_delay: assert property ($rose(awake) |-> hi_cnt >= WAKE_HIGH_CYC)
    else $error("awake before wake high delay");
  a_watchdog_bound: assert property (wd_cnt <= WATCHDOG_CYC + 4)
    else $error("watchdog did not return to sleep");
  a_ttl_copy: assert property ($stable(dev_addr) |=> thresh_ttl == dev_addr[3])
    else $error("threshold select differs from address bit");
endmodule : tw_target_properties

bind tw_target tw_target_properties #(
  .DEPTH(DEPTH), .WAKE_HIGH_CYC(WAKE_HIGH_CYC), .WATCHDOG_CYC(WATCHDOG_CYC)
) i_tw_target_properties (
  .clk_sys(clk_sys), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .dev_addr(dev_addr), .thresh_ttl(thresh_ttl), .awake(awake),
  .busy(busy), .exec_start(exec_start), .cmd_len(cmd_len), .exec_done(exec_done),
  .buf_rd_addr(buf_rd_addr), .buf_rd_data(buf_rd_data), .resp_data(resp_data),
  .resp_next(resp_next), .resp_rewind(resp_rewind), .sleep_req(sleep_req),
  .idle_req(idle_req)
);

/* File: testbench/tw_master.sv */
// two-wire bus master model driving the clock and pulling the data line
module tw_master #(parameter int HALF = 10) (
  input  wire logic       clk_sys,
  input  wire logic       sda_wire,
  output logic            scl,
  output logic            sda_low,
  output logic            res_valid,
  output logic [7:0]      res_val
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    scl       = 1'b1;
    sda_low   = 1'b0;
    res_valid = 1'b0;
    res_val   = 8'h00;
  end

  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : step

  task report(input logic [7:0] v);
    res_val   = v;
    res_valid = 1'b1;
    step(1);
    res_valid = 1'b0;
  endtask : report

  // data only moves two clocks after the fall, never beside the clock edge
  task bit_cyc(output logic s);
    step(HALF);
    scl = 1'b1;
    step(HALF);
    s   = sda_wire;
    scl = 1'b0;
    step(2);
  endtask : bit_cyc

  task start();
    sda_low = 1'b0;
    scl     = 1'b1;
    step(HALF);
    sda_low = 1'b1;
    step(HALF);
    scl = 1'b0;
    step(2);
  endtask : start

  task stop();
    sda_low = 1'b1;
    step(HALF);
    scl = 1'b1;
    step(HALF);
    sda_low = 1'b0;
    step(HALF);
  endtask : stop

  task put_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      sda_low = ~b[i];
      bit_cyc(s);
    end
    sda_low = 1'b0;
    bit_cyc(s);
    report({7'h00, ~s});
  endtask : put_byte

  task get_byte(input logic nack);
    logic [7:0] d;
    logic       s;
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--)
      bit_cyc(d[i]);
    sda_low = ~nack;
    bit_cyc(s);
    sda_low = 1'b0;
    report(d);
  endtask : get_byte

  task hold_low(input int n);
    sda_low = 1'b1;
    step(n);
    sda_low = 1'b0;
    step(HALF);
  endtask : hold_low
endmodule : tw_master

/* File: testbench/tb_tw_target.sv */
// self-checking bench for the two-wire target
module tb_tw_target;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int         WHC  = 20;
  localparam int         WDC  = 20000;
  localparam int         LOW  = tw_pkg::WAKE_LOW_CYC + 100;
  logic       clk_sys     = 1'b0;
  logic [7:0] dev_addr    = 8'hc8;
  logic       rst         = 1'b1;
  logic       exec_done   = 1'b0;
  logic [7:0] resp_data   = 8'h00;
  logic [5:0] buf_rd_addr = 6'h00;
  logic       scl, sda_low, sda_oe, sda_out, res_valid, thresh_ttl, awake, busy;
  logic       exec_start, resp_next, resp_rewind, sleep_req, idle_req;
  logic [7:0] res_val, cmd_len, buf_rd_data;
  logic [7:0] cmd [4];
  logic [7:0] exp_q [$];
  int         n_fail = 0;
  int         compares = 0;
  int         n_exec = 0;
  int         n_rew = 0;
  int         n_slp = 0;
  int         n_idl = 0;
  int         n_nxt = 0;
  // open-drain wire with pull-up
  wire        sda_wire = ~(sda_low | sda_oe);

  always #12.5 clk_sys = ~clk_sys;

  tw_master i_tw_master (.clk_sys(clk_sys), .sda_wire(sda_wire), .scl(scl),
    .sda_low(sda_low), .res_valid(res_valid), .res_val(res_val));

  tw_target #(.WAKE_HIGH_CYC(WHC), .WATCHDOG_CYC(WDC)) i_tw_target (
    .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe(sda_oe), .dev_addr(dev_addr), .thresh_ttl(thresh_ttl), .awake(awake),
    .busy(busy), .exec_start(exec_start), .cmd_len(cmd_len), .exec_done(exec_done),
    .buf_rd_addr(buf_rd_addr), .buf_rd_data(buf_rd_data), .resp_data(resp_data),
    .resp_next(resp_next), .resp_rewind(resp_rewind), .sleep_req(sleep_req),
    .idle_req(idle_req));

  task chk(input logic [7:0] seen_v, input logic [7:0] want);
    compares++;
    if (seen_v !== want)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen_v, want);
    end
  endtask : chk

  // pulse outputs are counted here so no single-cycle event is missed
  always @(posedge clk_sys)
  begin
    n_exec += (exec_start === 1'b1);
    n_rew  += (resp_rewind === 1'b1);
    n_slp  += (sleep_req === 1'b1);
    n_idl  += (idle_req === 1'b1);
    n_nxt  += (resp_next === 1'b1);
    if (res_valid === 1'b1)
      chk(res_val, exp_q.size() ? exp_q.pop_front() : ~res_val);
  end

  task put(input logic [7:0] b, input logic ack);
    exp_q.push_back({7'h00, ack});
    i_tw_master.put_byte(b);
  endtask : put

  task pkt(input logic [7:0] word, input logic word_ack);
    i_tw_master.start();
    put(dev_addr, 1'b1);
    put(word, word_ack);
  endtask : pkt

  task wake();
    int n;
    i_tw_master.hold_low(LOW);
    chk(awake, 1'b0);
    for (n = 0; n < WHC + 40 && awake !== 1'b1; n++)
      i_tw_master.step(1);
    chk(awake, 1'b1);
  endtask : wake

  task conclude();
    chk(exp_q.size(), 8'h00);
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  initial
  begin
    int n;
    void'($urandom(89984));
    // write direction needs bit zero clear; the rest of the address is random
    dev_addr = {7'($urandom), 1'b0};
    repeat (2) @(posedge clk_sys);
    #2;
    rst = 1'b0;
    i_tw_master.step(4);
    chk({awake, busy, sda_oe, exec_start}, 8'h00);
    chk(thresh_ttl, dev_addr[3]);
    i_tw_master.start();
    put(dev_addr, 1'b0);
    i_tw_master.stop();
    wake();
    i_tw_master.start();
    put(dev_addr ^ 8'h02, 1'b0);
    i_tw_master.stop();
    pkt(8'h04 + 8'($urandom_range(251)), 1'b0);
    i_tw_master.stop();
    pkt(8'h00, 1'b1);
    i_tw_master.stop();
    chk(n_rew, 8'h01);
    cmd[0] = 8'h03;
    for (int i = 1; i < 4; i++)
      cmd[i] = 8'($urandom);
    pkt(8'h03, 1'b1);
    for (int i = 0; i < 4; i++)
      put(cmd[i], 1'b1);
    chk(n_exec, 8'h01);
    chk(busy, 1'b1);
    i_tw_master.stop();
    buf_rd_addr = 6'h01;
    i_tw_master.step(3);
    chk(buf_rd_data, cmd[1]);
    chk(cmd_len, 8'h03);
    i_tw_master.start();
    put(dev_addr | 8'h01, 1'b0);
    i_tw_master.stop();
    exec_done = 1'b1;
    i_tw_master.step(1);
    exec_done = 1'b0;
    i_tw_master.step(3);
    chk(busy, 1'b0);
    chk(cmd_len, 8'h00);
    resp_data = 8'($urandom);
    i_tw_master.start();
    put(dev_addr | 8'h01, 1'b1);
    exp_q.push_back(resp_data);
    i_tw_master.get_byte(1'b1);
    chk(8'(n_nxt), 8'h01);
    i_tw_master.stop();
    i_tw_master.hold_low(LOW);
    chk(awake, 1'b1);
    pkt(8'h01, 1'b1);
    i_tw_master.stop();
    i_tw_master.step(3);
    chk({n_slp[3:0], 3'h0, awake}, 8'h10);
    wake();
    pkt(8'h02, 1'b1);
    i_tw_master.stop();
    i_tw_master.step(3);
    chk({n_idl[3:0], 3'h0, awake}, 8'h10);
    wake();
    for (n = 0; n < WDC + 100 && awake === 1'b1; n++)
      i_tw_master.step(1);
    chk(n > WDC - 20 && n < WDC + 20, 8'h01);
    conclude();
  end
endmodule : tb_tw_target
